// [pwr_seq_cfg.svh]
// Offsets, field positions, reset values and timing for the power state sequencer
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

`define OFS_AWAKE_CFG      8'h18
`define OFS_SLEEP_ONE_CFG  8'h1c
`define OFS_SLEEP_TWO_CFG  8'h20
`define OFS_SEQ_CTRL       8'h40
`define OFS_SEQ_STATUS     8'h44

`define DWELL_HI           20
`define DWELL_LO           16
`define STATE_HI           18
`define STATE_LO           16
`define BIT_CLK_GATE       14
`define BIT_ANA_PFM        9
`define BIT_CORE_PFM       8
`define BIT_IO_EN          5
`define BIT_PLL_EN         4
`define BIT_ANA_EN         1
`define BIT_CORE_EN        0
`define BIT_SLEEP_REQ      0

`define MASK_AWAKE_WR      32'h0000_4331
`define MASK_SLEEP_WR      32'h001f_4331
`define MASK_ANA_EN        32'h0000_0002

`define RST_AWAKE_CFG      32'h0000_0033
`define RST_SLEEP_ONE_CFG  32'h0010_0022
`define RST_SLEEP_TWO_CFG  32'h0010_0002
`define ASLEEP_CFG         32'h0000_0002
`define WAKE_ONE_CFG       32'h0010_0020
`define WAKE_TWO_CFG       32'h0010_0033

`define WAKE_DWELL_LOG2    5'h10
`define DWELL_CNT_W        32

`endif

// [pwr_seq_pkg.sv]
// Types shared by the power state sequencer
package pwr_seq_pkg;

	typedef enum logic [7:0] {
		st_reset     = 8'h01,
		st_asleep    = 8'h02,
		st_wake_one  = 8'h04,
		st_wake_two  = 8'h08,
		st_awake_wt  = 8'h10,
		st_awake     = 8'h20,
		st_sleep_one = 8'h40,
		st_sleep_two = 8'h80
	} state_t;

	typedef struct packed {
		logic clk_gate;
		logic ana_pfm;
		logic core_pfm;
		logic io_en;
		logic pll_en;
		logic ana_en;
		logic core_en;
	} supply_cfg_t;

	typedef struct packed {
		logic       io_good;
		logic       pll_good;
		logic       ana_good;
		logic       core_good;
	} supply_good_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_phase_t;

endpackage : pwr_seq_pkg

// [dwell_timer.sv]
// Log2 dwell counter for the timed sequencer states
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"

module dwell_timer (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       load_i,
	input  wire logic [4:0] log2_i,
	output logic            done_o
);

	logic [`DWELL_CNT_W-1:0] cnt_ff;
	logic [`DWELL_CNT_W-1:0] lim_ff;
	logic [`DWELL_CNT_W-1:0] nxt_lim;

	assign nxt_lim = (32'h1 << log2_i) - 32'h1;
	assign done_o  = (cnt_ff == lim_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 32'h0;
			lim_ff <= 32'h0;
		end else if (load_i) begin
			cnt_ff <= 32'h0;
			lim_ff <= nxt_lim;
		end else if (!done_o) begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end

	a_load_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i |=> cnt_ff == 32'h0 && lim_ff == (32'h1 << $past(log2_i)) - 32'h1)
		else $error("dwell limit not loaded as power of two");

	a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		!load_i && !done_o |=> cnt_ff == $past(cnt_ff) + 32'h1)
		else $error("dwell counter did not advance");

endmodule : dwell_timer

// [pwr_seq_ctrl.sv]
// Power state sequencer with per-state supply configuration over AHB-Lite
// Notes on behaviour
// - In the awake state the supply, modulation and clock gate outputs follow the awake register.
// - Each sleep-entry state lasts the dwell time held in its own register before moving on.
// - The dwell field in bits 20:16 gives 2^n clock cycles, resets to 16, n up to 31.
// - Bit 14 of the active state's register stops the processor clock while that state lasts.
// - Bit 9 picks PWM (0) or PFM (1) for the analogue-supply converter.
// - Bit 8 picks PWM (0) or PFM (1) for the core-supply converter.
// - Bit 5 enables the IO supply, resetting to 1 in awake and sleep one and 0 in sleep two.
// - Bit 4 enables the PLL supply regulator, resetting to 1 in awake and 0 in both sleep states.
// - Bit 1 is read-only and reads 1 in all three registers, so the analogue converter stays on except in wake one, whose fixed setting clears it.
// - Bit 0 enables the core-supply converter, resetting to 1 in awake and 0 in both sleep states.
// - The sequencer state reads as a three-bit code, 0 reset up to 7 sleep two.
// - A waking state ends only after its dwell and once every enabled supply is good.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"

module pwr_seq_ctrl #(
	parameter logic [4:0] WAKE_LOG2 = `WAKE_DWELL_LOG2
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire logic                       wake_i,
	input  wire pwr_seq_pkg::supply_good_t  pgood_i,
	output pwr_seq_pkg::supply_cfg_t        supply_o,
	output logic      [2:0]                 state_o
);

	// Register write: keep writable bits, force read-only ones
	function automatic logic [31:0] cfg_write(input logic [31:0] wdata,
	                                          input logic [31:0] mask);
		cfg_write = (wdata & mask) | `MASK_ANA_EN;
	endfunction : cfg_write

	function automatic pwr_seq_pkg::supply_cfg_t cfg_to_supply(input logic [31:0] word);
		pwr_seq_pkg::supply_cfg_t s;
		s.clk_gate = word[`BIT_CLK_GATE];
		s.ana_pfm  = word[`BIT_ANA_PFM];
		s.core_pfm = word[`BIT_CORE_PFM];
		s.io_en    = word[`BIT_IO_EN];
		s.pll_en   = word[`BIT_PLL_EN];
		s.ana_en   = word[`BIT_ANA_EN];
		s.core_en  = word[`BIT_CORE_EN];
		cfg_to_supply = s;
	endfunction : cfg_to_supply

	function automatic logic [2:0] state_code(input pwr_seq_pkg::state_t st);
		case (st)
			pwr_seq_pkg::st_reset:     state_code = 3'h0;
			pwr_seq_pkg::st_asleep:    state_code = 3'h1;
			pwr_seq_pkg::st_wake_one:  state_code = 3'h2;
			pwr_seq_pkg::st_wake_two:  state_code = 3'h3;
			pwr_seq_pkg::st_awake_wt:  state_code = 3'h4;
			pwr_seq_pkg::st_awake:     state_code = 3'h5;
			pwr_seq_pkg::st_sleep_one: state_code = 3'h6;
			default:                   state_code = 3'h7;
		endcase
	endfunction : state_code

	// Bus and register state
	pwr_seq_pkg::ahb_phase_t   dphase_ff;
	logic [31:0]               awake_ff;
	logic [31:0]               sleep_one_ff;
	logic [31:0]               sleep_two_ff;
	logic                      sleep_req_ff;
	logic [31:0]               hrdata_ff;
	pwr_seq_pkg::state_t       state_ff;
	pwr_seq_pkg::supply_cfg_t  supply_ff;

	pwr_seq_pkg::ahb_phase_t   nxt_dphase;
	logic [31:0]               nxt_awake;
	logic [31:0]               nxt_sleep_one;
	logic [31:0]               nxt_sleep_two;
	logic                      nxt_sleep_req;
	logic [31:0]               nxt_hrdata;
	pwr_seq_pkg::state_t       nxt_state;
	logic [31:0]               active_cfg;
	logic [4:0]                nxt_log2;

	// Address phase capture
	wire        addr_take   = hsel && htrans[1] && hready;
	assign nxt_dphase.valid = addr_take;
	assign nxt_dphase.write = hwrite;
	assign nxt_dphase.addr  = haddr[7:0];

	// Data-phase write decode
	wire wr_act       = dphase_ff.valid && dphase_ff.write;
	wire wr_awake     = wr_act && (dphase_ff.addr == `OFS_AWAKE_CFG);
	wire wr_sleep_one = wr_act && (dphase_ff.addr == `OFS_SLEEP_ONE_CFG);
	wire wr_sleep_two = wr_act && (dphase_ff.addr == `OFS_SLEEP_TWO_CFG);
	wire wr_ctrl      = wr_act && (dphase_ff.addr == `OFS_SEQ_CTRL);

	assign nxt_awake     = wr_awake ? cfg_write(hwdata, `MASK_AWAKE_WR) : awake_ff;
	assign nxt_sleep_one = wr_sleep_one ? cfg_write(hwdata, `MASK_SLEEP_WR) : sleep_one_ff;
	assign nxt_sleep_two = wr_sleep_two ? cfg_write(hwdata, `MASK_SLEEP_WR) : sleep_two_ff;

	// Request taken on leaving awake; a new write of one wins over that clear
	wire sleep_taken     = (state_ff == pwr_seq_pkg::st_awake) && sleep_req_ff;
	assign nxt_sleep_req = wr_ctrl ? hwdata[`BIT_SLEEP_REQ] : (sleep_req_ff && !sleep_taken);

	// Read decode from next values so a read right after a write sees it
	wire [31:0] status_word = {13'h0, state_code(state_ff), 1'h0,
	                           supply_ff.clk_gate, 4'h0,
	                           supply_ff.ana_pfm, supply_ff.core_pfm, 2'h0,
	                           supply_ff.io_en, supply_ff.pll_en, 2'h0,
	                           supply_ff.ana_en, supply_ff.core_en};
	wire [7:0]  rd_addr     = haddr[7:0];
	wire        rd_take     = addr_take && !hwrite;
	always_comb begin
		if (!rd_take)
			nxt_hrdata = 32'h0;
		else if (rd_addr == `OFS_AWAKE_CFG)
			nxt_hrdata = nxt_awake;
		else if (rd_addr == `OFS_SLEEP_ONE_CFG)
			nxt_hrdata = nxt_sleep_one;
		else if (rd_addr == `OFS_SLEEP_TWO_CFG)
			nxt_hrdata = nxt_sleep_two;
		else if (rd_addr == `OFS_SEQ_CTRL)
			nxt_hrdata = {31'h0, nxt_sleep_req};
		else if (rd_addr == `OFS_SEQ_STATUS)
			nxt_hrdata = status_word;
		else
			nxt_hrdata = 32'h0;
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Every enabled supply reports good
	wire all_good = (pgood_i.io_good   || !supply_ff.io_en)
	             && (pgood_i.pll_good  || !supply_ff.pll_en)
	             && (pgood_i.ana_good  || !supply_ff.ana_en)
	             && (pgood_i.core_good || !supply_ff.core_en);

	logic dwell_done;

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pwr_seq_pkg::st_reset:
				nxt_state = pwr_seq_pkg::st_wake_one;
			pwr_seq_pkg::st_asleep:
				if (wake_i) begin
					nxt_state = pwr_seq_pkg::st_wake_one;
				end
			pwr_seq_pkg::st_wake_one:
				if (dwell_done && all_good) begin
					nxt_state = pwr_seq_pkg::st_wake_two;
				end
			pwr_seq_pkg::st_wake_two:
				if (dwell_done && all_good) begin
					nxt_state = pwr_seq_pkg::st_awake_wt;
				end
			pwr_seq_pkg::st_awake_wt:
				if (all_good) begin
					nxt_state = pwr_seq_pkg::st_awake;
				end
			pwr_seq_pkg::st_awake:
				if (sleep_req_ff) begin
					nxt_state = pwr_seq_pkg::st_sleep_one;
				end
			pwr_seq_pkg::st_sleep_one:
				if (dwell_done) begin
					nxt_state = pwr_seq_pkg::st_sleep_two;
				end
			pwr_seq_pkg::st_sleep_two:
				if (dwell_done) begin
					nxt_state = pwr_seq_pkg::st_asleep;
				end
			default:
				nxt_state = pwr_seq_pkg::st_reset;
		endcase
	end

	// Dwell of the state being entered
	always_comb begin
		case (nxt_state)
			pwr_seq_pkg::st_sleep_one: nxt_log2 = sleep_one_ff[`DWELL_HI:`DWELL_LO];
			pwr_seq_pkg::st_sleep_two: nxt_log2 = sleep_two_ff[`DWELL_HI:`DWELL_LO];
			pwr_seq_pkg::st_wake_one:  nxt_log2 = WAKE_LOG2;
			pwr_seq_pkg::st_wake_two:  nxt_log2 = WAKE_LOG2;
			default:                   nxt_log2 = 5'h0;
		endcase
	end

	wire state_change = (nxt_state != state_ff);

	dwell_timer u_dwell (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (state_change),
		.log2_i (nxt_log2),
		.done_o (dwell_done)
	);

	// Configuration of the state now active
	always_comb begin
		case (state_ff)
			pwr_seq_pkg::st_wake_one:  active_cfg = `WAKE_ONE_CFG;
			pwr_seq_pkg::st_wake_two:  active_cfg = `WAKE_TWO_CFG;
			pwr_seq_pkg::st_awake_wt:  active_cfg = awake_ff;
			pwr_seq_pkg::st_awake:     active_cfg = awake_ff;
			pwr_seq_pkg::st_sleep_one: active_cfg = sleep_one_ff;
			pwr_seq_pkg::st_sleep_two: active_cfg = sleep_two_ff;
			default:                   active_cfg = `ASLEEP_CFG;
		endcase
	end

	assign supply_o = supply_ff;
	assign state_o  = state_code(state_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dphase_ff    <= '0;
			awake_ff     <= `RST_AWAKE_CFG;
			sleep_one_ff <= `RST_SLEEP_ONE_CFG;
			sleep_two_ff <= `RST_SLEEP_TWO_CFG;
			sleep_req_ff <= 1'b0;
			hrdata_ff    <= 32'h0;
			state_ff     <= pwr_seq_pkg::st_reset;
			supply_ff    <= cfg_to_supply(`ASLEEP_CFG);
		end else begin
			dphase_ff    <= nxt_dphase;
			awake_ff     <= nxt_awake;
			sleep_one_ff <= nxt_sleep_one;
			sleep_two_ff <= nxt_sleep_two;
			sleep_req_ff <= nxt_sleep_req;
			hrdata_ff    <= nxt_hrdata;
			state_ff     <= nxt_state;
			supply_ff    <= cfg_to_supply(active_cfg);
		end
	end

	a_awake_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_awake |=> supply_ff == cfg_to_supply($past(awake_ff)))
		else $error("awake outputs differ from awake register");

	a_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_sleep_one && !dwell_done
		|=> state_ff == pwr_seq_pkg::st_sleep_one)
		else $error("sleep one left before its dwell");

	a_sleep_two_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_sleep_two && !dwell_done
		|=> state_ff == pwr_seq_pkg::st_sleep_two)
		else $error("sleep two left before its dwell");

	a_dwell_two: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_awake && sleep_req_ff
		&& sleep_one_ff[`DWELL_HI:`DWELL_LO] == 5'h1
		|=> state_ff == pwr_seq_pkg::st_sleep_one [*2]
		##1 state_ff == pwr_seq_pkg::st_sleep_two)
		else $error("dwell of one did not last two cycles");

	a_gate_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_sleep_two
		|=> supply_ff.clk_gate == $past(sleep_two_ff[`BIT_CLK_GATE]))
		else $error("clock gate does not follow sleep two register");

	a_mod_select: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_sleep_one
		|=> supply_ff.ana_pfm == $past(sleep_one_ff[`BIT_ANA_PFM])
		&& supply_ff.core_pfm == $past(sleep_one_ff[`BIT_CORE_PFM]))
		else $error("modulation select mismatch");

	a_reset_vals: assert property (@(posedge clk_i)
		rst_i |=> awake_ff == `RST_AWAKE_CFG && sleep_one_ff == `RST_SLEEP_ONE_CFG
		&& sleep_two_ff == `RST_SLEEP_TWO_CFG
		&& supply_ff == cfg_to_supply(`ASLEEP_CFG))
		else $error("state register reset value wrong");

	a_ana_ro: assert property (@(posedge clk_i) disable iff (rst_i)
		awake_ff[`BIT_ANA_EN] && sleep_one_ff[`BIT_ANA_EN] && sleep_two_ff[`BIT_ANA_EN])
		else $error("analogue converter enable cleared");

	a_state_code: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_sleep_two |-> state_o == 3'h7)
		else $error("state code wrong");

	a_wake_good: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_wake_one && !all_good
		|=> state_ff == pwr_seq_pkg::st_wake_one)
		else $error("waking advanced with a supply not good");

	a_wake_two_good: assert property (@(posedge clk_i) disable iff (rst_i)
		state_ff == pwr_seq_pkg::st_wake_two && !(dwell_done && all_good)
		|=> state_ff == pwr_seq_pkg::st_wake_two)
		else $error("second waking step left too early");

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(awake_ff & ~(`MASK_AWAKE_WR | `MASK_ANA_EN)) == 32'h0
		&& (sleep_one_ff & ~(`MASK_SLEEP_WR | `MASK_ANA_EN)) == 32'h0
		&& (sleep_two_ff & ~(`MASK_SLEEP_WR | `MASK_ANA_EN)) == 32'h0)
		else $error("reserved bit set in state register");

endmodule : pwr_seq_ctrl

// [supply_model.sv]
// Regulator and power-good model for the sequencer's supply outputs
`timescale 1ns/1ps

module supply_model #(
	parameter int DELAY = 3
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire pwr_seq_pkg::supply_cfg_t supply_i,
	output pwr_seq_pkg::supply_good_t     pgood_o
);
	logic [3:0] en;
	int         ramp_ff [4];

	assign en = {supply_i.io_en, supply_i.pll_en, supply_i.ana_en, supply_i.core_en};

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			// Disabled rail collapses at once, enabled rail ramps
			if (rst_i || !en[i]) begin
				ramp_ff[i] <= 0;
			end else if (ramp_ff[i] < DELAY) begin
				ramp_ff[i] <= ramp_ff[i] + 1;
			end
		end
	end

	// Good is pulled low on any rail that is off or still ramping
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pgood_o[i] = en[i] && (ramp_ff[i] == DELAY);
		end
	end
endmodule : supply_model

// [power_state_supply_config_bench.sv]
// Self-checking bench for the power state sequencer
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"

module power_state_supply_config_bench;
	logic                      clk_i;
	logic                      rst_i;
	logic                      hsel;
	logic [31:0]               haddr;
	logic [1:0]                htrans;
	logic                      hwrite;
	logic [2:0]                hsize;
	logic [31:0]               hwdata;
	logic [31:0]               hrdata;
	logic                      hreadyout;
	logic                      hresp;
	logic                      wake_i;
	pwr_seq_pkg::supply_good_t pgood_i;
	pwr_seq_pkg::supply_cfg_t  supply_o;
	logic [2:0]                state_o;
	int                        failures;
	int                        n_checks;
	logic [31:0]               q;
	logic [31:0]               r;
	logic [31:0]               s1;
	logic [31:0]               s2;
	int                        n1;
	int                        n2;
	int                        cnt;

	pwr_seq_ctrl #(.WAKE_LOG2(5'h02)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_i(wake_i),
		.pgood_i(pgood_i), .supply_o(supply_o), .state_o(state_o)
	);

	supply_model #(.DELAY(3)) i_supplies (
		.clk_i(clk_i), .rst_i(rst_i), .supply_i(supply_o), .pgood_o(pgood_i)
	);

	always #50 clk_i = ~clk_i;

	task automatic wrap_up;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [6:0] exp_supply(input logic [31:0] c);
		return {c[14], c[9], c[8], c[5], c[4], c[1], c[0]};
	endfunction : exp_supply

	// Single AHB-Lite transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		int k;
		k = 0;
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin @(posedge clk_i); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do begin @(posedge clk_i); k++; end while (hreadyout !== 1'b1 && k < 50);
		// Data taken at the edge that ends the data phase
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
		if (k >= 50) begin
			failures++;
			wrap_up();
		end
	endtask : bus

	task automatic wait_state(input logic [2:0] c, input int lim);
		int k;
		k = 0;
		do begin @(negedge clk_i); k++; end while (state_o !== c && k < lim);
		chk({29'h0, state_o}, {29'h0, c});
		if (state_o !== c) begin
			wrap_up();
		end
	endtask : wait_state

	// Counts cycles spent in a state, checks outputs one cycle after entry
	task automatic dwell(input logic [2:0] c, input logic [31:0] cfg, output int n);
		n = 0;
		while (state_o === c && n < 300) begin
			@(negedge clk_i);
			n++;
			if (n == 1) begin
				chk({25'h0, supply_o}, {25'h0, exp_supply(cfg)});
			end
		end
	endtask : dwell

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		wake_i = 1'b0;
		failures = 0;
		n_checks = 0;
		void'($urandom(32'h589c));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 8'h18, 32'h0, q);
		chk(q, 32'h0000_0033);
		bus(1'b0, 8'h1c, 32'h0, q);
		chk(q, 32'h0010_0022);
		bus(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0010_0002);
		bus(1'b1, 8'h1c, 32'hffff_ffff, q);
		bus(1'b0, 8'h1c, 32'h0, q);
		chk(q, 32'h001f_4333);
		bus(1'b1, 8'h18, 32'hffff_ffff, q);
		bus(1'b0, 8'h18, 32'h0, q);
		chk(q, 32'h0000_4333);
		bus(1'b1, 8'h20, 32'h0, q);
		bus(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0000_0002);
		bus(1'b0, 8'h3c, 32'h0, q);
		chk(q, 32'h0);
		wait_state(3'd5, 400);
		for (int it = 0; it < 4; it++) begin
			r = (it == 0) ? 32'h0000_4331 : ($urandom & 32'h0000_4331);
			bus(1'b1, 8'h18, r, q);
			repeat (2) @(negedge clk_i);
			chk({25'h0, supply_o}, {25'h0, exp_supply(r | 32'h2)});
			bus(1'b0, 8'h44, 32'h0, q);
			chk(q, 32'h0005_0002 | r);
			n1 = (it == 0) ? 0 : ((it == 1) ? 1 : $urandom_range(4, 1));
			n2 = (it == 1) ? 0 : $urandom_range(4, 0);
			s1 = ($urandom & 32'h0000_4331) | (n1 << 16);
			s2 = ($urandom & 32'h0000_4331) | (n2 << 16);
			bus(1'b1, 8'h1c, s1, q);
			bus(1'b1, 8'h20, s2, q);
			bus(1'b1, 8'h40, 32'h1, q);
			wait_state(3'd6, 20);
			dwell(3'd6, s1 | 32'h2, cnt);
			chk(cnt, 1 << n1);
			dwell(3'd7, s2 | 32'h2, cnt);
			chk(cnt, 1 << n2);
			chk({29'h0, state_o}, 32'h1);
			@(posedge clk_i);
			wake_i <= 1'b1;
			wait_state(3'd2, 20);
			dwell(3'd2, `WAKE_ONE_CFG, cnt);
			chk(cnt >= 4, 32'h1);
			@(posedge clk_i);
			wake_i <= 1'b0;
			wait_state(3'd5, 400);
		end
		wrap_up();
	end
endmodule : power_state_supply_config_bench
